// >>> bench/icu_mem_model.sv
// Purpose: Program and data memory on the far side of the core
// Assumes: Combinational reads, byte write on the strobe
// Notes:   Program words are loaded by the bench
`timescale 1ns/1ps
`default_nettype none
module icu_mem_model (
    input  wire logic        clk_in,
    input  wire logic [11:0] prog_addr_in,
    output logic [17:0]      prog_data_out,
    input  wire logic [7:0]  dmem_addr_in,
    input  wire logic [7:0]  dmem_wdata_in,
    input  wire logic        dmem_we_in,
    output logic [7:0]       dmem_rdata_out
);
    logic [17:0] rom [0:4095];
    logic [7:0]  ram [0:255];
    // Data memory starts cleared
    initial
    begin
        for (int i = 0; i < 256; i++)
            ram[i] = 8'h00;
    end
    // Combinational reads
    assign prog_data_out  = rom[prog_addr_in];
    assign dmem_rdata_out = ram[dmem_addr_in];
    // Byte write on the strobe
    always @(posedge clk_in)
    begin
        if (dmem_we_in)
            ram[dmem_addr_in] <= dmem_wdata_in;
    end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench of the instruction cycle core
// Assumes: Core at 50 MHz with the memory model
// Notes:   Program mixes one- and two-cycle instructions
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [11:0] pa;
    logic [17:0] pd;
    logic [7:0]  da, dw, dr, acc, r1, r2;
    logic        we, done, ie, ov_e;
    logic [3:0]  flags;
    logic [9:0]  th;
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [7:0]  exp_acc [$];
    int          exp_gap [$];
    int          gap_n = 0, n_errors = 0, comparisons = 0;
    always #10 clk_in = ~clk_in;
    icu_core icu_core_i (.clk_in(clk_in), .rst_in(rst_in), .prog_addr_out(pa),
        .prog_data_in(pd), .dmem_addr_out(da), .dmem_wdata_out(dw), .dmem_we_out(we),
        .dmem_rdata_in(dr), .acc_out(acc), .flags_out(flags), .table_high_out(th),
        .int_enable_out(ie), .instr_done_out(done));
    icu_mem_model icu_mem_model_i (.clk_in(clk_in), .prog_addr_in(pa), .prog_data_out(pd),
        .dmem_addr_in(da), .dmem_wdata_in(dw), .dmem_we_in(we), .dmem_rdata_out(dr));
    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Result of every finished instruction, and spacing of all but the first
    always @(posedge clk_in)
    begin
        gap_n <= gap_n + 1;
        if (!rst_in && done === 1'b1 && exp_acc.size() > 0)
        begin
            check("acc", {8'h00, acc}, {8'h00, exp_acc.pop_front()});
            if (exp_gap[0] != 0)
                check("gap", 16'(gap_n), 16'(exp_gap[0]));
            void'(exp_gap.pop_front());
            gap_n <= 1;
        end
    end
    // Watchdog
    initial
    begin
        #40000;
        n_errors++;
        complete_run();
    end
    initial
    begin
        r1 = 8'($urandom(32'h6c30));
        r1 = 8'($urandom());
        r2 = 8'($urandom());
        icu_mem_model_i.rom[0] = {icu_pkg::OP_XIA, 4'h0, r1};
        icu_mem_model_i.rom[1] = {icu_pkg::OP_XAM, 12'h010};
        icu_mem_model_i.rom[2] = {icu_pkg::OP_ADD1A, 12'h010};
        icu_mem_model_i.rom[3] = {icu_pkg::OP_CALL, 12'h020};
        icu_mem_model_i.rom[4] = {icu_pkg::OP_GOTO, 12'h008};
        icu_mem_model_i.rom[8] = {icu_pkg::OP_XIA, 12'h000};
        icu_mem_model_i.rom[9] = {icu_pkg::OP_SKZ, 12'h011};
        icu_mem_model_i.rom[10] = {icu_pkg::OP_XIA, 12'h0ff};
        icu_mem_model_i.rom[11] = {icu_pkg::OP_XIA, 4'h0, r2};
        // Add, logic, rotate, untaken skip, table read, low pc jump, interrupt exit
        icu_mem_model_i.rom[12] = {icu_pkg::OP_ADD, 12'h010};
        icu_mem_model_i.rom[13] = {icu_pkg::OP_AND, 12'h011};
        icu_mem_model_i.rom[14] = {icu_pkg::OP_ROTLC, 12'h010};
        icu_mem_model_i.rom[15] = {icu_pkg::OP_SKBNZ, 12'h011};
        icu_mem_model_i.rom[16] = {icu_pkg::OP_TBRD, 12'h012};
        icu_mem_model_i.rom[17] = {icu_pkg::OP_XMA, 12'h012};
        icu_mem_model_i.rom[18] = {icu_pkg::OP_XIA, 12'h016};
        icu_mem_model_i.rom[19] = {icu_pkg::OP_XAM, 12'h006};
        icu_mem_model_i.rom[20] = {icu_pkg::OP_XIA, 12'h0ff};
        icu_mem_model_i.rom[22] = {icu_pkg::OP_CALL, 12'h028};
        icu_mem_model_i.rom[23] = {icu_pkg::OP_GOTO, 12'h017};
        icu_mem_model_i.rom[32] = {icu_pkg::OP_SUB1A, 12'h010};
        icu_mem_model_i.rom[33] = {icu_pkg::OP_EXIT, 12'h000};
        icu_mem_model_i.rom[40] = {icu_pkg::OP_IEXIT, 12'h000};
        // Model of the add: sum, half carry and signed overflow
        sum9 = {1'b0, r1} + {1'b0, r2};
        nib5 = {1'b0, r1[3:0]} + {1'b0, r2[3:0]};
        ov_e = (r1[7] == r2[7]) && (sum9[7] != r1[7]);
        exp_acc = '{r1, r1, r1 + 8'h01, r1 + 8'h01, r1 - 8'h01, r1 - 8'h01,
                    r1 - 8'h01, 8'h00, 8'h00, r2, sum9[7:0], 8'h00, 8'h00, 8'h00,
                    8'h00, r1, 8'h16, 8'h16, 8'h16, 8'h16, 8'h16};
        exp_gap = '{0, 4, 4, 8, 4, 8, 8, 4, 8, 4, 4, 4, 4, 4, 8, 4, 4, 8, 8, 8, 8};
        repeat (5) @(posedge clk_in);
        check("reset_acc", {8'h00, acc}, 16'h0000);
        $display("Reset test done");
        rst_in <= 1'b0;
        for (int i = 0; i < 300 && exp_acc.size() > 0; i++)
            @(posedge clk_in);
        check("pending", 16'(exp_acc.size()), 16'h0000);
        check("mem", {8'h00, icu_mem_model_i.ram[16]}, {8'h00, r1[6:0], sum9[8]});
        check("table_lo", {8'h00, icu_mem_model_i.ram[18]}, {8'h00, r1});
        check("table_hi", {6'h00, th}, {6'h00, icu_pkg::OP_XIA, 4'h0});
        check("flags", {12'h000, flags}, {12'h000, ov_e, nib5[4], r1[7], 1'b1});
        check("int_enable", {15'h0000, ie}, 16'h0001);
        $display("Program test done");
        complete_run();
    end
endmodule
`default_nettype wire

// >>> rtl/icu_alu.sv
// Purpose: Byte datapath for arithmetic, logic and rotate operations
// Assumes: a_in is the accumulator, b_in the operand; unary ops use b_in
// Notes:   Carry output carries borrow (1 = borrow) for subtraction
`timescale 1ns/1ps
`default_nettype none
module icu_alu (
    input  wire icu_pkg::icu_alu_type fn_in,
    input  wire logic [7:0]           a_in,
    input  wire logic [7:0]           b_in,
    input  wire logic                 c_in,
    output logic [7:0]                res_out,
    output logic                      c_out,
    output logic                      ac_out,
    output logic                      ov_out,
    output logic                      z_out
);
    logic       sub;
    logic       ci;
    logic [7:0] bx;
    logic [4:0] lo5;
    logic [8:0] s9;

    // Shared adder; SUB is a plus inverted b plus one, SBC a plus inverted b plus inverted carry
    always_comb
    begin
        sub = (fn_in == icu_pkg::ALU_SUB) || (fn_in == icu_pkg::ALU_SBC);
        bx  = sub ? ~b_in : b_in;
        case (fn_in)
            icu_pkg::ALU_ADC: ci = c_in;
            icu_pkg::ALU_SUB: ci = 1'b1;
            icu_pkg::ALU_SBC: ci = ~c_in;
            default:          ci = 1'b0;
        endcase
        lo5 = {1'b0, a_in[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
        s9  = {1'b0, a_in} + {1'b0, bx} + {8'h00, ci};
        res_out = b_in;
        c_out   = c_in;
        ac_out  = 1'b0;
        ov_out  = 1'b0;
        case (fn_in)
            icu_pkg::ALU_ADD, icu_pkg::ALU_ADC, icu_pkg::ALU_SUB, icu_pkg::ALU_SBC:
            begin
                res_out = s9[7:0];
                c_out   = s9[8] ^ sub;
                ac_out  = lo5[4] ^ sub;
                ov_out  = (a_in[7] == bx[7]) && (s9[7] != a_in[7]);
            end
            icu_pkg::ALU_AND:   res_out = a_in & b_in;
            icu_pkg::ALU_OR:    res_out = a_in | b_in;
            icu_pkg::ALU_XOR:   res_out = a_in ^ b_in;
            icu_pkg::ALU_CMPL:  res_out = ~b_in;
            icu_pkg::ALU_ADD1:  res_out = b_in + 8'h01;
            icu_pkg::ALU_SUB1:  res_out = b_in - 8'h01;
            icu_pkg::ALU_ROTR:  res_out = {b_in[0], b_in[7:1]};
            icu_pkg::ALU_ROTL:  res_out = {b_in[6:0], b_in[7]};
            icu_pkg::ALU_ROTRC:
            begin
                res_out = {c_in, b_in[7:1]};
                c_out   = b_in[0];
            end
            icu_pkg::ALU_ROTLC:
            begin
                res_out = {b_in[6:0], c_in};
                c_out   = b_in[7];
            end
            default:            res_out = b_in;
        endcase
        z_out = (res_out == 8'h00);
    end
endmodule
`default_nettype wire

// >>> rtl/icu_core.sv
// Purpose: Instruction cycle sequencing and execution of the core
// Assumes: Program and data memory answer within one clock, same clock
// Notes:   Two-cycle instructions run a second, non-executing cycle
`timescale 1ns/1ps
`default_nettype none
module icu_core (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    output logic [11:0]      prog_addr_out,
    input  wire logic [17:0] prog_data_in,
    output logic [7:0]       dmem_addr_out,
    output logic [7:0]       dmem_wdata_out,
    output logic             dmem_we_out,
    input  wire logic [7:0]  dmem_rdata_in,
    output logic [7:0]       acc_out,
    output logic [3:0]       flags_out,
    output logic [9:0]       table_high_out,
    output logic             int_enable_out,
    output logic             instr_done_out
);
    logic [1:0]  phase_w;
    logic [11:0] pc_q, pc_d, pa_q, pa_d;
    logic [17:0] ir_q, ir_d, tw_q, tw_d;
    logic [7:0]  da_q, da_d, wd_q, wd_d, mdr_q, mdr_d, acc_q, acc_d;
    logic        we_q, we_d, dm_q, dm_d, tb_q, tb_d, ie_q, ie_d, dn_q, dn_d;
    logic        z_q, z_d, c_q, c_d, ac_q, ac_d, ov_q, ov_d;
    logic [9:0]  th_q, th_d;
    logic [1:0]  sp_q, sp_d;
    logic [11:0] stk_q [icu_pkg::STACK_DEPTH];
    logic [11:0] stk_d [icu_pkg::STACK_DEPTH];

    icu_pkg::icu_op_type  op_w;
    icu_pkg::icu_alu_type fn_w;
    logic [7:0]  b_w, res_w, mask_w;
    logic        rc_w, rac_w, rov_w, rz_w;
    logic        dmem_w, dacc_w, fa_w, fz_w, fc_w, skop_w, skip_w;
    logic        exec_w, lowpc_w;
    logic [11:0] pc1_w, pc2_w, top_w, nxt;

    icu_phase u_phase (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .phase_out (phase_w)
    );

    // Operation decode: function, operand source and destination
    always_comb
    begin
        op_w   = icu_pkg::icu_op_type'(ir_q[17:12]);
        mask_w = 8'h01 << ir_q[10:8];
        case (op_w)
            icu_pkg::OP_ADD, icu_pkg::OP_ADDM, icu_pkg::OP_ADDX: fn_w = icu_pkg::ALU_ADD;
            icu_pkg::OP_ADC:  fn_w = icu_pkg::ALU_ADC;
            icu_pkg::OP_SUB, icu_pkg::OP_SUBM, icu_pkg::OP_SUBX: fn_w = icu_pkg::ALU_SUB;
            icu_pkg::OP_SBC:  fn_w = icu_pkg::ALU_SBC;
            icu_pkg::OP_AND, icu_pkg::OP_ANDM, icu_pkg::OP_ANDX: fn_w = icu_pkg::ALU_AND;
            icu_pkg::OP_OR, icu_pkg::OP_ORM:   fn_w = icu_pkg::ALU_OR;
            icu_pkg::OP_XOR, icu_pkg::OP_XORM: fn_w = icu_pkg::ALU_XOR;
            icu_pkg::OP_CMPL, icu_pkg::OP_CMPLA: fn_w = icu_pkg::ALU_CMPL;
            icu_pkg::OP_ADD1M, icu_pkg::OP_ADD1A, icu_pkg::OP_SKINC: fn_w = icu_pkg::ALU_ADD1;
            icu_pkg::OP_SUB1M, icu_pkg::OP_SUB1A: fn_w = icu_pkg::ALU_SUB1;
            icu_pkg::OP_ROTR:  fn_w = icu_pkg::ALU_ROTR;
            icu_pkg::OP_ROTL:  fn_w = icu_pkg::ALU_ROTL;
            icu_pkg::OP_ROTRC: fn_w = icu_pkg::ALU_ROTRC;
            icu_pkg::OP_ROTLC: fn_w = icu_pkg::ALU_ROTLC;
            default:           fn_w = icu_pkg::ALU_PASS;
        endcase
        // Operand b: memory byte, accumulator, immediate, zero or bit-edited byte
        case (op_w)
            icu_pkg::OP_XAM:  b_w = acc_q;
            icu_pkg::OP_XIA, icu_pkg::OP_ADDX, icu_pkg::OP_SUBX,
            icu_pkg::OP_ANDX: b_w = ir_q[7:0];
            icu_pkg::OP_CLRM: b_w = icu_pkg::BYTE_RST;
            icu_pkg::OP_BSET: b_w = mdr_q | mask_w;
            icu_pkg::OP_BCLR: b_w = mdr_q & ~mask_w;
            default:          b_w = mdr_q;
        endcase
        // Results land in acc or memory; the acc is always one ALU input
        dacc_w = op_w inside {icu_pkg::OP_XMA, icu_pkg::OP_XIA, icu_pkg::OP_ADD,
                 icu_pkg::OP_ADDX, icu_pkg::OP_ADC, icu_pkg::OP_SUB, icu_pkg::OP_SUBX,
                 icu_pkg::OP_SBC, icu_pkg::OP_AND, icu_pkg::OP_OR, icu_pkg::OP_XOR,
                 icu_pkg::OP_ANDX, icu_pkg::OP_CMPLA, icu_pkg::OP_ADD1A,
                 icu_pkg::OP_SUB1A};
        dmem_w = op_w inside {icu_pkg::OP_XAM, icu_pkg::OP_ADDM, icu_pkg::OP_SUBM,
                 icu_pkg::OP_ANDM, icu_pkg::OP_ORM, icu_pkg::OP_XORM, icu_pkg::OP_CMPL,
                 icu_pkg::OP_ADD1M, icu_pkg::OP_SUB1M, icu_pkg::OP_ROTR, icu_pkg::OP_ROTL,
                 icu_pkg::OP_ROTRC, icu_pkg::OP_ROTLC, icu_pkg::OP_CLRM, icu_pkg::OP_BSET,
                 icu_pkg::OP_BCLR, icu_pkg::OP_SKINC};
        fa_w = fn_w inside {icu_pkg::ALU_ADD, icu_pkg::ALU_ADC, icu_pkg::ALU_SUB,
               icu_pkg::ALU_SBC};
        fz_w = (fa_w || (fn_w inside {icu_pkg::ALU_AND, icu_pkg::ALU_OR, icu_pkg::ALU_XOR,
               icu_pkg::ALU_CMPL, icu_pkg::ALU_ADD1, icu_pkg::ALU_SUB1}))
               && (op_w != icu_pkg::OP_SKINC);
        fc_w = fn_w inside {icu_pkg::ALU_ROTRC, icu_pkg::ALU_ROTLC};
    end

    icu_alu u_alu (
        .fn_in   (fn_w),
        .a_in    (acc_q),
        .b_in    (b_w),
        .c_in    (c_q),
        .res_out (res_w),
        .c_out   (rc_w),
        .ac_out  (rac_w),
        .ov_out  (rov_w),
        .z_out   (rz_w)
    );

    // Skip tests and program counter candidates
    always_comb
    begin
        pc1_w  = pc_q + icu_pkg::PC_ONE;
        pc2_w  = pc_q + icu_pkg::PC_TWO;
        top_w  = stk_q[sp_q - 2'h1];
        exec_w = (phase_w == icu_pkg::PHASE_LAST) && !dm_q;
        lowpc_w = dmem_w && (da_q == icu_pkg::PC_LOW_ADDR);
        skop_w = op_w inside {icu_pkg::OP_SKZ, icu_pkg::OP_SKBZ, icu_pkg::OP_SKBNZ,
                 icu_pkg::OP_SKINC};
        case (op_w)
            icu_pkg::OP_SKZ:   skip_w = (mdr_q == icu_pkg::BYTE_RST);
            icu_pkg::OP_SKBZ:  skip_w = !(|(mdr_q & mask_w));
            icu_pkg::OP_SKBNZ: skip_w = |(mdr_q & mask_w);
            icu_pkg::OP_SKINC: skip_w = rz_w;
            default:           skip_w = 1'b0;
        endcase
    end

    // Next state of the whole core, stepped by the phase counter
    always_comb
    begin
        pc_d = pc_q;
        pa_d = pa_q;
        ir_d = ir_q;
        tw_d = tw_q;
        da_d = da_q;
        wd_d = wd_q;
        mdr_d = mdr_q;
        acc_d = acc_q;
        we_d = 1'b0;
        dn_d = 1'b0;
        dm_d = dm_q;
        tb_d = tb_q;
        ie_d = ie_q;
        z_d = z_q;
        c_d = c_q;
        ac_d = ac_q;
        ov_d = ov_q;
        th_d = th_q;
        sp_d = sp_q;
        stk_d = stk_q;
        nxt = pc1_w;
        case (phase_w)
            icu_pkg::PHASE_RST:
            begin
                if (!dm_q)
                begin
                    ir_d = prog_data_in;
                    da_d = prog_data_in[7:0];
                end
            end
            icu_pkg::PHASE_RD:
            begin
                if (tb_q)
                    tw_d = prog_data_in;
                else if (!dm_q)
                    mdr_d = (da_q == icu_pkg::PC_LOW_ADDR) ? pc_q[7:0] : dmem_rdata_in;
            end
            icu_pkg::PHASE_LAST:
            begin
                if (dm_q)
                begin
                    // Second cycle: finish a table read, refetch at pc
                    dm_d = 1'b0;
                    tb_d = 1'b0;
                    dn_d = 1'b1;
                    pa_d = pc_q;
                    if (tb_q)
                    begin
                        we_d = 1'b1;
                        wd_d = tw_q[7:0];
                        th_d = tw_q[17:8];
                    end
                end
                else
                begin
                    case (op_w)
                        icu_pkg::OP_GOTO:
                        begin
                            nxt = ir_q[11:0];
                            dm_d = 1'b1;
                        end
                        icu_pkg::OP_CALL:
                        begin
                            stk_d[sp_q] = pc1_w;
                            sp_d = sp_q + 2'h1;
                            nxt = ir_q[11:0];
                            dm_d = 1'b1;
                        end
                        icu_pkg::OP_EXIT, icu_pkg::OP_IEXIT:
                        begin
                            sp_d = sp_q - 2'h1;
                            nxt = top_w;
                            dm_d = 1'b1;
                            ie_d = ie_q || (op_w == icu_pkg::OP_IEXIT);
                        end
                        icu_pkg::OP_TBRD:
                        begin
                            tb_d = 1'b1;
                            dm_d = 1'b1;
                        end
                        default:
                        begin
                            if (dacc_w)
                                acc_d = res_w;
                            if (lowpc_w)
                            begin
                                nxt = {pc_q[11:8], res_w};
                                dm_d = 1'b1;
                            end
                            else if (dmem_w)
                            begin
                                we_d = 1'b1;
                                wd_d = res_w;
                            end
                            if (skip_w)
                            begin
                                nxt = pc2_w;
                                dm_d = 1'b1;
                            end
                        end
                    endcase
                    if (fz_w)
                        z_d = rz_w;
                    if (fa_w || fc_w)
                        c_d = rc_w;
                    if (fa_w)
                    begin
                        ac_d = rac_w;
                        ov_d = rov_w;
                    end
                    pc_d = nxt;
                    pa_d = (op_w == icu_pkg::OP_TBRD) ? {pc_q[11:8], acc_q} : nxt;
                    dn_d = !dm_d;
                end
            end
            default:
            begin
                dn_d = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pc_q <= icu_pkg::PC_RST;
            pa_q <= icu_pkg::PC_RST;
            ir_q <= '0;
            tw_q <= '0;
            da_q <= icu_pkg::BYTE_RST;
            wd_q <= icu_pkg::BYTE_RST;
            mdr_q <= icu_pkg::BYTE_RST;
            acc_q <= icu_pkg::BYTE_RST;
            {we_q, dn_q, dm_q, tb_q, ie_q} <= 5'h00;
            {z_q, c_q, ac_q, ov_q} <= 4'h0;
            th_q <= '0;
            sp_q <= icu_pkg::SP_RST;
            for (int i = 0; i < icu_pkg::STACK_DEPTH; i++)
                stk_q[i] <= icu_pkg::PC_RST;
        end
        else
        begin
            pc_q <= pc_d;
            pa_q <= pa_d;
            ir_q <= ir_d;
            tw_q <= tw_d;
            da_q <= da_d;
            wd_q <= wd_d;
            mdr_q <= mdr_d;
            acc_q <= acc_d;
            {we_q, dn_q, dm_q, tb_q, ie_q} <= {we_d, dn_d, dm_d, tb_d, ie_d};
            {z_q, c_q, ac_q, ov_q} <= {z_d, c_d, ac_d, ov_d};
            th_q <= th_d;
            sp_q <= sp_d;
            stk_q <= stk_d;
        end
    end

    assign prog_addr_out  = pa_q;
    assign dmem_addr_out  = da_q;
    assign dmem_wdata_out = wd_q;
    assign dmem_we_out    = we_q;
    assign acc_out        = acc_q;
    assign flags_out      = {ov_q, ac_q, c_q, z_q};
    assign table_high_out = th_q;
    assign int_enable_out = ie_q;
    assign instr_done_out = dn_q;

    // Spacing between completions, for the checks below
    logic [3:0] gap_q;
    logic       lng_q, seen_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            {gap_q, lng_q, seen_q} <= 6'h00;
        else
        begin
            gap_q  <= dn_q ? 4'h0 : gap_q + 4'h1;
            lng_q  <= dn_q ? 1'b0 : (lng_q | dm_q);
            seen_q <= seen_q | dn_q;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    single_len_a: assert property (
        dn_q && seen_q && !lng_q |-> gap_q == icu_pkg::GAP_ONE)
        else $error("Single-cycle instruction not four clocks");
    double_len_a: assert property (
        dn_q && seen_q && lng_q |-> gap_q == icu_pkg::GAP_TWO)
        else $error("Two-cycle instruction not eight clocks");
    goto_target_a: assert property (
        exec_w && op_w == icu_pkg::OP_GOTO |=> pc_q == $past(ir_q[11:0])
        && dm_q && sp_q == $past(sp_q))
        else $error("Goto target or stack wrong");
    call_link_a: assert property (
        exec_w && op_w == icu_pkg::OP_CALL |=> stk_q[$past(sp_q)] == $past(pc1_w) && dm_q)
        else $error("Call did not save following address");
    exit_resume_a: assert property (
        exec_w && op_w == icu_pkg::OP_EXIT |=> pc_q == $past(top_w) ##4 dn_q)
        else $error("Subroutine exit wrong address or length");
    low_pc_jump_a: assert property (
        exec_w && lowpc_w && !skop_w |=> dm_q && !we_q && pc_q[7:0] == $past(res_w))
        else $error("Low pc write not a jump");
    skip_taken_a: assert property (
        exec_w && skop_w && skip_w |=> dm_q && pc_q == $past(pc2_w))
        else $error("Taken skip wrong");
    skip_not_a: assert property (
        exec_w && skop_w && !skip_w |=> !dm_q && pc_q == $past(pc1_w))
        else $error("Untaken skip wrong");
    add_carry_a: assert property (
        exec_w && op_w == icu_pkg::OP_ADD |=>
        c_q == (({1'b0, $past(acc_q)} + {1'b0, $past(mdr_q)}) > 9'h0ff))
        else $error("Add carry wrong");
    rot_carry_a: assert property (
        exec_w && op_w == icu_pkg::OP_ROTLC |=> c_q == $past(mdr_q[7])
        && wd_q == {$past(mdr_q[6:0]), $past(c_q)})
        else $error("Rotate via carry wrong");
    zero_flag_a: assert property (
        exec_w && op_w == icu_pkg::OP_AND |=> z_q == (acc_q == 8'h00))
        else $error("Logic zero flag wrong");

    call_seen_c:  cover property (exec_w && op_w == icu_pkg::OP_CALL);
    skip_seen_c:  cover property (exec_w && skop_w && skip_w);
    table_seen_c: cover property (tb_q && we_d);
    low_pc_seen_c: cover property (exec_w && lowpc_w);
endmodule
`default_nettype wire

// >>> rtl/icu_phase.sv
// Purpose: Four-phase sequencer of the instruction cycle
// Assumes: One system clock, asynchronous active-high reset
// Notes:   Phase wraps 0..3 without pause
`timescale 1ns/1ps
`default_nettype none
module icu_phase (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    output logic [1:0]      phase_out
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;

    // Next phase, wrapping after the last one
    always_comb
    begin
        phase_d = phase_q + icu_pkg::PHASE_STEP;
    end

    // Phase register, back to phase zero on reset
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            phase_q <= icu_pkg::PHASE_RST;
        else
            phase_q <= phase_d;
    end

    assign phase_out = phase_q;

    phase_wrap_a: assert property (@(posedge clk_in) disable iff (rst_in)
        phase_q == 2'h0 |=> phase_q == 2'h1 ##1 phase_q == 2'h2
        ##1 phase_q == 2'h3 ##1 phase_q == 2'h0)
        else $error("Instruction cycle is not four clocks");

    phase_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> phase_q == 2'h0)
        else $error("Phase not zero after reset");
endmodule
`default_nettype wire

// >>> rtl/icu_pkg.sv
// Purpose: Shared constants and types for the instruction cycle core
// Assumes: 18-bit instruction word, opcode in [17:12], operand in [11:0]
// Notes:   Opcode and ALU function codes are local to this core
package icu_pkg;

    // Phase sequencing
    localparam logic [1:0]  PHASE_RST   = 2'h0;
    localparam logic [1:0]  PHASE_STEP  = 2'h1;
    localparam logic [1:0]  PHASE_RD    = 2'h2;
    localparam logic [1:0]  PHASE_LAST  = 2'h3;

    // Widths and depths
    localparam int          PC_W        = 12;
    localparam int          IW          = 18;
    localparam int          STACK_DEPTH = 4;

    // Special data address, reset values, pc steps and completion gaps
    localparam logic [7:0]  PC_LOW_ADDR = 8'h06;
    localparam logic [11:0] PC_RST      = 12'h000;
    localparam logic [11:0] PC_ONE      = 12'h001;
    localparam logic [11:0] PC_TWO      = 12'h002;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam logic [1:0]  SP_RST      = 2'h0;
    localparam logic [3:0]  GAP_ONE     = 4'h3;
    localparam logic [3:0]  GAP_TWO     = 4'h7;

    typedef enum logic [5:0] {
        OP_NOP   = 6'h00, OP_XMA   = 6'h01, OP_XAM   = 6'h02, OP_XIA   = 6'h03,
        OP_ADD   = 6'h04, OP_ADDM  = 6'h05, OP_ADDX  = 6'h06, OP_ADC   = 6'h07,
        OP_SUB   = 6'h08, OP_SUBM  = 6'h09, OP_SUBX  = 6'h0A, OP_SBC   = 6'h0B,
        OP_AND   = 6'h0C, OP_OR    = 6'h0D, OP_XOR   = 6'h0E, OP_ANDM  = 6'h0F,
        OP_ORM   = 6'h10, OP_XORM  = 6'h11, OP_ANDX  = 6'h12, OP_CMPL  = 6'h13,
        OP_CMPLA = 6'h14, OP_ADD1M = 6'h15, OP_ADD1A = 6'h16, OP_SUB1M = 6'h17,
        OP_SUB1A = 6'h18, OP_ROTR  = 6'h19, OP_ROTL  = 6'h1A, OP_ROTRC = 6'h1B,
        OP_ROTLC = 6'h1C, OP_CLRM  = 6'h1D, OP_BSET  = 6'h1E, OP_BCLR  = 6'h1F,
        OP_SKZ   = 6'h20, OP_SKBZ  = 6'h21, OP_SKBNZ = 6'h22, OP_SKINC = 6'h23,
        OP_GOTO  = 6'h24, OP_CALL  = 6'h25, OP_EXIT  = 6'h26, OP_IEXIT = 6'h27,
        OP_TBRD  = 6'h28
    } icu_op_type;

    typedef enum logic [3:0] {
        ALU_PASS  = 4'h0, ALU_ADD   = 4'h1, ALU_ADC   = 4'h2, ALU_SUB  = 4'h3,
        ALU_SBC   = 4'h4, ALU_AND   = 4'h5, ALU_OR    = 4'h6, ALU_XOR  = 4'h7,
        ALU_CMPL  = 4'h8, ALU_ADD1  = 4'h9, ALU_SUB1  = 4'hA, ALU_ROTR = 4'hB,
        ALU_ROTL  = 4'hC, ALU_ROTRC = 4'hD, ALU_ROTLC = 4'hE
    } icu_alu_type;

endpackage
